/* File: common/mbsm_pkg.sv */
// Constants, carriers and state record of the multibuffer serial master.
// Assumes one bus clock of 25 MHz and a synchronous active-low reset.
package mbsm_pkg;
  // ----------------------------------------------------------------
  // Buffer array and control bits
  // ----------------------------------------------------------------
  localparam int          DEPTH      = 256;
  localparam int          AW         = 8;
  localparam int          GCR_MASTER = 0;
  localparam int          CTRL_FSEL  = 8;
  localparam int          CTRL_KEEP  = 12;
  localparam logic [15:0] ST_RX      = 16'h0001;
  localparam logic [15:0] ST_SLV     = 16'h0002;
  localparam logic [4:0]  LEN_MIN    = 5'h02;
  localparam logic [4:0]  LEN_MAX    = 5'h10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PS       = 40000;
  localparam int         SCLK_MIN_PS  = 25000;
  localparam logic [8:0] SCLK_MIN_CYC =
    9'((SCLK_MIN_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [8:0] PS0_PER      = 9'h002;
  localparam logic [9:0] LEAD_ADD     = 10'h002;
  localparam logic [9:0] KEEP_ADD     = 10'h001;
  localparam logic [9:0] TRAIL_ADD    = 10'h001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_LOAD  = 7'h02,
    S_LEAD  = 7'h04,
    S_SHIFT = 7'h08,
    S_TRAIL = 7'h10,
    S_STORE = 7'h20,
    S_SLAVE = 7'h40
  } mbsm_state_e;

  typedef struct packed {
    logic [13:0] rsv_hi;
    logic        pol;
    logic        pha;
    logic [7:0]  ps;
    logic [2:0]  rsv_lo;
    logic [4:0]  len;
  } mbsm_fmt_s;

  typedef struct packed {
    logic [7:0]  c2t;
    logic [7:0]  t2c;
    logic [15:0] rsv;
  } mbsm_dly_s;

  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [15:0] tx;
    logic [15:0] ctrl;
  } mbsm_wr_s;

  typedef struct packed {
    logic       trig;
    logic [7:0] first;
    logic [7:0] last;
  } mbsm_grp_s;

  typedef struct packed {
    logic ck_m, ck_s, ck_p, cs_m, cs_s, si_m, si_s, so_m, so_s;
  } mbsm_sync_s;

  typedef struct packed {
    mbsm_state_e     st;
    logic [7:0]      idx;
    logic [15:0]     sh;
    logic [15:0]     rx;
    logic [9:0]      cnt;
    logic [5:0]      edges;
    logic [4:0]      len;
    logic [7:0]      ph1, ph2, c2t, t2c;
    logic            pol, pha, keep, slv;
    logic            sclk, sclk_oe, simo, simo_oe;
    logic            somi, somi_oe, cs_n, cs_oe;
    logic            busy, done;
    mbsm_sync_s      sy;
    logic [1:0][15:0] fdat;
    logic            fwr, frd;
    logic [1:0]      fcnt;
    logic            ov;
    logic [15:0]     od, rd_rx, rd_st;
  } mbsm_st_s;
endpackage : mbsm_pkg

/* File: hw/mbsm_master.sv */
// Multibuffer serial port: controller with buffer RAM, peripheral fallback.
// Assumes format, delay, group and write inputs come from same-clock logic;
// serial pins come from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module mbsm_master (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic [15:0]       i_gcr,
  input  wire mbsm_pkg::mbsm_fmt_s i_fmt0,
  input  wire mbsm_pkg::mbsm_fmt_s i_fmt1,
  input  wire mbsm_pkg::mbsm_dly_s i_dly,
  input  wire mbsm_pkg::mbsm_grp_s i_grp,
  input  wire mbsm_pkg::mbsm_wr_s  i_wr,
  input  wire logic [7:0]        i_rd_addr,
  input  wire logic              i_rx_ready,
  input  wire logic              i_sclk,
  input  wire logic              i_simo,
  input  wire logic              i_somi,
  input  wire logic              i_cs_n,
  output logic                   o_sclk,
  output logic                   o_sclk_oe,
  output logic                   o_simo,
  output logic                   o_simo_oe,
  output logic                   o_somi,
  output logic                   o_somi_oe,
  output logic                   o_cs_n,
  output logic                   o_cs_oe,
  output logic                   o_busy,
  output logic                   o_group_done,
  output logic [7:0]             o_cur_index,
  output logic                   o_rx_valid,
  output logic [15:0]            o_rx_data,
  output logic [15:0]            o_rd_rx,
  output logic [15:0]            o_rd_status
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] len_fit(input logic [4:0] l);
    len_fit = (l < mbsm_pkg::LEN_MIN) ? mbsm_pkg::LEN_MIN
            : (l > mbsm_pkg::LEN_MAX) ? mbsm_pkg::LEN_MAX : l;
  endfunction : len_fit
  function automatic logic [8:0] period(input logic [7:0] ps);
    logic [8:0] p;
    p = (ps == 8'h00) ? mbsm_pkg::PS0_PER : {1'b0, ps} + 9'h001;
    period = (p < mbsm_pkg::SCLK_MIN_CYC) ? mbsm_pkg::SCLK_MIN_CYC : p;
  endfunction : period
  function automatic logic [7:0] next_idx(input logic [7:0] i,
                                          input logic [7:0] f,
                                          input logic [7:0] l);
    next_idx = (i == l) ? f : i + 8'h01;
  endfunction : next_idx
  function automatic mbsm_pkg::mbsm_st_s load_word(
    input mbsm_pkg::mbsm_st_s  s,
    input mbsm_pkg::mbsm_fmt_s f,
    input mbsm_pkg::mbsm_dly_s d,
    input logic [15:0]         tx,
    input logic                keep);
    logic [8:0]  per;
    logic [15:0] al;
    load_word       = s;
    load_word.len   = len_fit(f.len);
    per             = period(f.ps);
    load_word.ph1   = per[8:1];
    load_word.ph2   = 8'(per - {1'b0, per[8:1]});
    load_word.pha   = f.pha;
    load_word.pol   = f.pol;
    load_word.keep  = keep;
    load_word.c2t   = d.c2t;
    load_word.t2c   = d.t2c;
    load_word.rx    = 16'h0000;
    load_word.edges = 6'h00;
    al = tx << (mbsm_pkg::LEN_MAX - load_word.len);
    if (!f.pha) begin
      load_word.simo = al[15];
      load_word.somi = al[15];
      load_word.sh   = {al[14:0], 1'b0};
    end else begin
      load_word.sh = al;
    end
  endfunction : load_word
  // ----------------------------------------------------------------
  // Buffer RAM
  // ----------------------------------------------------------------
  logic [15:0] tx_mem   [mbsm_pkg::DEPTH];
  logic [15:0] ctrl_mem [mbsm_pkg::DEPTH];
  logic [15:0] rx_mem   [mbsm_pkg::DEPTH];
  logic [15:0] st_mem   [mbsm_pkg::DEPTH];
  mbsm_pkg::mbsm_st_s  q;
  mbsm_pkg::mbsm_st_s  n;
  mbsm_pkg::mbsm_fmt_s w_f;
  logic [15:0]         w_ctl;
  logic                rx_we;
  logic                master;
  assign master = i_gcr[mbsm_pkg::GCR_MASTER];
  assign w_ctl  = ctrl_mem[q.idx];
  assign w_f    = w_ctl[mbsm_pkg::CTRL_FSEL] ? i_fmt1 : i_fmt0;
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_wr.we) begin
        tx_mem[i_wr.addr]   <= i_wr.tx;
        ctrl_mem[i_wr.addr] <= i_wr.ctrl;
      end
      if (rx_we) begin
        rx_mem[q.idx] <= q.rx;
        st_mem[q.idx] <= q.slv ? (mbsm_pkg::ST_RX | mbsm_pkg::ST_SLV)
                               : mbsm_pkg::ST_RX;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = q;
    rx_we    = 1'b0;
    n.done   = 1'b0;
    n.sy = {i_sclk, q.sy.ck_m, q.sy.ck_s, i_cs_n, q.sy.cs_m,
            i_simo, q.sy.si_m, i_somi, q.sy.so_m};
    n.cs_oe   = master;
    n.sclk_oe = master;
    n.simo_oe = master;
    n.rd_rx   = rx_mem[i_rd_addr];
    n.rd_st   = st_mem[i_rd_addr];
    if (i_rx_ready && q.ov) begin
      n.frd  = ~q.frd;
      n.fcnt = q.fcnt - 2'h1;
    end
    case (q.st)
      mbsm_pkg::S_IDLE: begin
        n.cs_n    = 1'b1;
        n.sclk    = i_fmt0.pol;
        n.somi_oe = 1'b0;
        n.busy    = 1'b0;
        if (master && i_grp.trig) begin
          n.idx  = i_grp.first;
          n.busy = 1'b1;
          n.st   = mbsm_pkg::S_LOAD;
        end else if (!master && !q.sy.cs_s) begin
          n         = load_word(n, i_fmt0, i_dly, tx_mem[q.idx], 1'b0);
          n.slv     = 1'b1;
          n.somi_oe = 1'b1;
          n.st      = mbsm_pkg::S_SLAVE;
        end
      end
      mbsm_pkg::S_LOAD: begin
        n = load_word(n, w_f, i_dly, tx_mem[q.idx],
                      w_ctl[mbsm_pkg::CTRL_KEEP]);
        n.slv  = 1'b0;
        n.cs_n = 1'b0;
        n.sclk = n.pol;
        n.cnt  = {2'h0, n.c2t} + mbsm_pkg::LEAD_ADD
               + (n.keep ? mbsm_pkg::KEEP_ADD : 10'h000)
               - 10'h001;
        n.st   = mbsm_pkg::S_LEAD;
      end
      mbsm_pkg::S_LEAD: begin
        if (q.cnt == 10'h001) n.st = mbsm_pkg::S_SHIFT;
        else n.cnt = q.cnt - 10'h001;
      end
      mbsm_pkg::S_SHIFT: begin
        if (q.cnt == 10'h001) begin
          n.sclk  = ~q.sclk;
          n.edges = q.edges + 6'h01;
          if (~q.edges[0] ^ q.pha) begin
            n.rx = {q.rx[14:0], q.sy.so_s};
          end else begin
            n.simo = q.sh[15];
            n.sh   = {q.sh[14:0], 1'b0};
          end
          if (n.edges == {q.len, 1'b0}) begin
            n.st  = mbsm_pkg::S_TRAIL;
            n.cnt = {2'h0, q.ph1} + {2'h0, q.t2c}
                  + mbsm_pkg::TRAIL_ADD;
          end else begin
            n.cnt = q.edges[0] ? {2'h0, q.ph2} : {2'h0, q.ph1};
          end
        end else begin
          n.cnt = q.cnt - 10'h001;
        end
      end
      mbsm_pkg::S_TRAIL: begin
        if (q.cnt == 10'h001) begin
          n.cs_n = ~(q.keep && q.idx != i_grp.last);
          n.st   = mbsm_pkg::S_STORE;
        end else begin
          n.cnt = q.cnt - 10'h001;
        end
      end
      mbsm_pkg::S_STORE: begin
        if (q.fcnt != 2'h2) begin
          rx_we          = 1'b1;
          n.fdat[q.fwr]  = q.rx;
          n.fwr          = ~q.fwr;
          n.fcnt         = n.fcnt + 2'h1;
          if (q.slv) begin
            n.idx = next_idx(q.idx, i_grp.first, i_grp.last);
            n.st  = mbsm_pkg::S_IDLE;
          end else if (q.idx == i_grp.last) begin
            n.done = 1'b1;
            n.busy = 1'b0;
            n.st   = mbsm_pkg::S_IDLE;
          end else begin
            n.idx = next_idx(q.idx, i_grp.first, i_grp.last);
            n.st  = mbsm_pkg::S_LOAD;
          end
        end
      end
      mbsm_pkg::S_SLAVE: begin
        if (q.sy.cs_s) begin
          n.somi_oe = 1'b0;
          n.st      = mbsm_pkg::S_IDLE;
        end else if (q.sy.ck_s != q.sy.ck_p) begin
          if ((q.sy.ck_s != q.pol) ^ q.pha) begin
            n.rx    = {q.rx[14:0], q.sy.si_s};
            n.edges = q.edges + 6'h01;
            if (n.edges == {1'b0, q.len}) n.st = mbsm_pkg::S_STORE;
          end else begin
            n.somi = q.sh[15];
            n.sh   = {q.sh[14:0], 1'b0};
          end
        end
      end
      default: n.st = mbsm_pkg::S_IDLE;
    endcase
    n.ov = n.fcnt != 2'h0;
    n.od = n.fdat[n.frd];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q      <= '0;
      q.st   <= mbsm_pkg::S_IDLE;
      q.cs_n <= 1'b1;
      q.sy   <= '1;
    end else if (i_ce) begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sclk       = q.sclk;
  assign o_sclk_oe    = q.sclk_oe;
  assign o_simo       = q.simo;
  assign o_simo_oe    = q.simo_oe;
  assign o_somi       = q.somi;
  assign o_somi_oe    = q.somi_oe;
  assign o_cs_n       = q.cs_n;
  assign o_cs_oe      = q.cs_oe;
  assign o_busy       = q.busy;
  assign o_group_done = q.done;
  assign o_cur_index  = q.idx;
  assign o_rx_valid   = q.ov;
  assign o_rx_data    = q.od;
  assign o_rd_rx      = q.rd_rx;
  assign o_rd_status  = q.rd_st;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [9:0] lc, tc, hc;
  logic       hs, chg;
  assign chg = q.sclk != hs;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lc <= 10'h000;
      tc <= 10'h000;
      hc <= 10'h000;
      hs <= 1'b0;
    end else if (i_ce) begin
      lc <= (q.st == mbsm_pkg::S_LOAD) ? 10'h000 : lc + 10'h001;
      tc <= (q.st == mbsm_pkg::S_SHIFT) ? 10'h000 : tc + 10'h001;
      hc <= chg ? 10'h001 : hc + 10'h001;
      hs <= q.sclk;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_master_drives: assert property (
    i_ce && master |=> o_sclk_oe && o_simo_oe && o_cs_oe)
    else $error("master mode does not drive its lines");
  chk_idle_level: assert property (
    q.st == mbsm_pkg::S_LEAD |-> o_sclk == q.pol && !o_cs_n)
    else $error("clock not at idle level during lead");
  chk_lead_time: assert property (
    q.st == mbsm_pkg::S_SHIFT && q.edges == 6'h01 && chg
    |-> lc == {2'h0, q.c2t} + mbsm_pkg::LEAD_ADD
              + (q.keep ? mbsm_pkg::KEEP_ADD : 10'h000))
    else $error("select to first edge delay wrong");
  chk_trail_time: assert property (
    q.st == mbsm_pkg::S_STORE && $past(q.st) == mbsm_pkg::S_TRAIL
    && o_cs_n && !q.slv
    |-> tc == {2'h0, q.ph1} + {2'h0, q.t2c} + mbsm_pkg::TRAIL_ADD)
    else $error("last edge to select release delay wrong");
  chk_half_period: assert property (
    q.st == mbsm_pkg::S_SHIFT && chg && q.edges > 6'h01
    |-> hc == (q.edges[0] ? {2'h0, q.ph2} : {2'h0, q.ph1}))
    else $error("serial clock half period wrong");
  chk_word_edges: assert property (
    q.st == mbsm_pkg::S_TRAIL && $past(q.st) == mbsm_pkg::S_SHIFT
    |-> q.edges == {q.len, 1'b0} && q.len >= mbsm_pkg::LEN_MIN)
    else $error("edge count does not match word length");
  chk_store_entry: assert property (
    i_ce && rx_we && !q.slv && q.idx != i_grp.last
    |=> q.idx == $past(q.idx) + 8'h01 && q.st == mbsm_pkg::S_LOAD)
    else $error("next entry not selected after store");
  chk_phase0_data: assert property (
    !q.pha && q.st == mbsm_pkg::S_SHIFT && chg && q.edges[0]
    |-> o_simo == $past(o_simo))
    else $error("data moved on phase-zero sampling edge");
  chk_buffer_room: assert property (
    rx_we |-> q.fcnt != 2'h2 ##1 o_rx_valid)
    else $error("word stored into full buffer");
endmodule : mbsm_master

`default_nettype wire

/* File: testbench/mbsm_periph.sv */
// Behavioural serial peripheral on the controller pins.
// Assumes polarity and phase are set before a word starts.
`timescale 1ns/1ps
`default_nettype none
module mbsm_periph (
  input  wire logic   i_sclk,
  input  wire logic   i_cs_n,
  input  wire logic   i_mosi,
  input  wire logic   i_pol,
  input  wire logic   i_pha,
  output logic        o_miso,
  output logic [15:0] o_got,
  output logic        o_done
);
  logic [15:0] reply  = 16'h9c41;
  logic [15:0] out_sh = 16'h0000;
  logic [15:0] in_sh  = 16'h0000;
  logic        act    = 1'b0;

  initial begin
    o_miso = 1'b0;
    o_got  = 16'h0000;
    o_done = 1'b0;
  end

  // ----------------------------------------------------------------
  // Word start, shifting, word end
  // ----------------------------------------------------------------
  always @(negedge i_cs_n) begin
    act    = 1'b1;
    out_sh = reply;
    in_sh  = 16'h0000;
    if (!i_pha) begin
      o_miso = out_sh[15];
      out_sh = out_sh << 1;
    end
  end

  always @(i_sclk) begin
    if (act && ((i_sclk != i_pol) == !i_pha)) begin
      in_sh = {in_sh[14:0], i_mosi};
    end else if (act) begin
      o_miso = out_sh[15];
      out_sh = out_sh << 1;
    end
  end

  // Released line shows the inverse of its last value
  always @(posedge i_cs_n) begin
    if (act) begin
      act    = 1'b0;
      o_miso = ~o_miso;
      o_got  = in_sh;
      reply  = reply + 16'h3b1d;
      o_done = 1'b1;
      #1 o_done = 1'b0;
    end
  end
endmodule : mbsm_periph
`default_nettype wire

/* File: testbench/mbsm_master_tb_top.sv */
// Self-checking bench for the multibuffer serial master.
// Assumes the peripheral model sits on pulled-up controller pins.
`timescale 1ns/1ps
`default_nettype none
module mbsm_master_tb_top;
  typedef struct packed {
    logic [15:0] d;
    logic [15:0] m;
  } mbsm_exp_s;
  typedef struct packed {
    logic [15:0] lead;
    logic [15:0] per;
    logic [15:0] trail;
    logic        pol;
  } mbsm_tm_s;

  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rdy = 1'b1;
  logic pol = 1'b0, pha = 1'b0;
  logic [15:0] gcr = 16'h0000, rep = 16'h9c41;
  logic [7:0]  rda = 8'h00, a, cidx;
  mbsm_pkg::mbsm_fmt_s f0 = '0, f1 = '0;
  mbsm_pkg::mbsm_dly_s dly = '0;
  mbsm_pkg::mbsm_grp_s grp = '0;
  mbsm_pkg::mbsm_wr_s  wr  = '0;
  logic sclk, sclk_oe, simo, simo_oe, somi, somi_oe, cs_n, cs_oe;
  logic busy, gdone, rxv, pe_miso, pe_done;
  logic pin_sclk, pin_simo, pin_somi, pin_cs_n;
  logic [15:0] rxd, rdrx, rdst, pe_got;
  logic [7:0]  pv [3] = '{8'h00, 8'h01, 8'hff};
  int errors = 0, n_compared = 0, cyc = 0, t0, t1, t2, tl;
  logic [15:0] txm [256];
  mbsm_exp_s   rxm [256];
  mbsm_exp_s   q_rx[$], q_tx[$], ea, eb;
  mbsm_tm_s    q_tm[$], et;

  assign pin_sclk = sclk_oe ? sclk : 1'b1;
  assign pin_simo = simo_oe ? simo : 1'b1;
  assign pin_cs_n = cs_oe ? cs_n : 1'b1;
  assign pin_somi = somi_oe ? somi : pe_miso;

  mbsm_master dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_gcr(gcr),
    .i_fmt0(f0), .i_fmt1(f1), .i_dly(dly), .i_grp(grp), .i_wr(wr),
    .i_rd_addr(rda), .i_rx_ready(rdy), .i_sclk(pin_sclk),
    .i_simo(pin_simo), .i_somi(pin_somi), .i_cs_n(pin_cs_n),
    .o_sclk(sclk), .o_sclk_oe(sclk_oe), .o_simo(simo),
    .o_simo_oe(simo_oe), .o_somi(somi), .o_somi_oe(somi_oe),
    .o_cs_n(cs_n), .o_cs_oe(cs_oe), .o_busy(busy),
    .o_group_done(gdone), .o_cur_index(cidx), .o_rx_valid(rxv),
    .o_rx_data(rxd), .o_rd_rx(rdrx), .o_rd_status(rdst));

  mbsm_periph pe_u (
    .i_sclk(pin_sclk), .i_cs_n(pin_cs_n), .i_mosi(pin_simo),
    .i_pol(pol), .i_pha(pha), .o_miso(pe_miso), .o_got(pe_got),
    .o_done(pe_done));

  // ----------------------------------------------------------------
  // Clock, timeout, shared tasks
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // Writes an entry and notes its expected word and timing
  task automatic put(input logic [7:0] ad, input logic [15:0] ct);
    mbsm_pkg::mbsm_fmt_s f;
    logic [15:0] m, p;
    f = ct[mbsm_pkg::CTRL_FSEL] ? f1 : f0;
    m = 16'hffff >> (16 - f.len);
    p = (f.ps == 8'h00) ? 16'h0002 : 16'(f.ps) + 16'h0001;
    txm[ad] = 16'($urandom);
    rxm[ad] = '{16'(rep >> (16 - f.len)), (p < 16'h8) ? 16'h0 : m};
    rep = rep + 16'h3b1d;
    q_rx.push_back(rxm[ad]);
    q_tx.push_back('{txm[ad], m});
    q_tm.push_back('{16'(dly.c2t) + 16'h2 + 16'(ct[mbsm_pkg::CTRL_KEEP]),
                     p, p / 2 + 16'(dly.t2c) + 16'h1, f.pol});
    wr = '{1'b1, ad, txm[ad], ct};
    step();
  endtask : put

  // Starts a group, optionally stalls the receiver, waits for done
  task automatic run(input logic [7:0] fa, input logic [7:0] la,
                     input int hold);
    int k;
    wr.we = 1'b0;
    grp = '{1'b1, fa, la};
    step();
    grp.trig = 1'b0;
    if (hold > 0) begin
      step(hold);
      chk("stalled busy", 1'b1, busy);
    end
    k = 0;
    while (gdone !== 1'b1 && k < 20000) begin
      rdy = (hold > 0) ? 1'($urandom) : 1'b1;
      step();
      k++;
    end
    chk("group done", 1'b1, gdone);
    chk("last index", 16'(la), 16'(cidx));
    chk("somi oe", 1'b0, somi_oe);
    rdy = 1'b1;
    step();
  endtask : run

  task automatic rd(input logic [7:0] ad);
    rda = ad;
    step(2);
    chk("stored rx", rxm[ad].d & rxm[ad].m, rdrx & rxm[ad].m);
    chk("status", mbsm_pkg::ST_RX, rdst & 16'h0003);
  endtask : rd

  // ----------------------------------------------------------------
  // Output watchers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rxv === 1'b1 && rdy === 1'b1) begin
      ea = q_rx.pop_front();
      chk("rx word", ea.d & ea.m, rxd & ea.m);
    end
  end

  always @(posedge pe_done) begin
    eb = q_tx.pop_front();
    chk("sent word", eb.d & eb.m, pe_got & eb.m);
  end

  always @(negedge pin_cs_n) begin
    et = q_tm.pop_front();
    t0 = cyc;
    chk("idle clock", 16'(et.pol), 16'(pin_sclk));
    @(pin_sclk) t1 = cyc;
    @(pin_sclk);
    @(pin_sclk) t2 = cyc;
    tl = t2;
    while (pin_cs_n === 1'b0) begin
      @(pin_sclk or pin_cs_n);
      if (pin_cs_n === 1'b0) tl = cyc;
    end
    chk("lead", et.lead, 16'(t1 - t0));
    chk("period", et.per, 16'(t2 - t1));
    chk("trail", et.trail, 16'(cyc - tl));
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(80404));
    f0.len = 5'h08;
    f0.ps = 8'h07;
    step(12);
    rst_n = 1'b1;
    chk("cs idle", 1'b1, cs_n);
    grp = '{1'b1, 8'h00, 8'h00};
    step(3);
    chk("oe off", 1'b0, sclk_oe);
    chk("busy off", 1'b0, busy);
    grp.trig = 1'b0;
    gcr = 16'h0001;
    step(2);
    chk("oe on", 1'b1, sclk_oe);
    $display("test mode select done");
    for (int i = 0; i < 6; i++) begin
      f0.pol = i[0];
      f0.pha = i[1];
      f0.len = (i == 4) ? 5'h02 : (i == 5) ? 5'h10 : 5'(2 + $urandom % 15);
      f0.ps = 8'(7 + $urandom % 6);
      dly = '{8'(1 + $urandom % 5), 8'($urandom % 6), 16'h0000};
      pol = f0.pol;
      pha = f0.pha;
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      put(a, 16'(i[0] ^ i[1]) << mbsm_pkg::CTRL_KEEP);
      run(a, a, 0);
      rd(a);
    end
    $display("test modes and lengths done");
    for (int j = 0; j < 3; j++) begin
      f0.ps = pv[j];
      f0.len = 5'h02;
      put(8'h20, 16'h0000);
      run(8'h20, 8'h20, 0);
    end
    $display("test prescale done");
    f0.ps = 8'h07;
    f0.len = 5'h05;
    f1 = f0;
    f1.len = 5'h10;
    f1.ps = 8'h09;
    rdy = 1'b0;
    for (int k = 16; k < 19; k++) put(8'(k), (k == 17) ? 16'h0100 : 16'h0);
    run(8'h10, 8'h12, 1500);
    for (int k = 16; k < 19; k++) rd(8'(k));
    step(20);
    chk("rx left", 16'h0000, 16'(q_rx.size()));
    $display("test group and stall done");
    test_done();
  end
endmodule : mbsm_master_tb_top
`default_nettype wire
